// ### rtl/tbg_pkg.sv
// Constants for the timebase generator and counter routing block
// Function
// - Master timebase runs from the onboard oscillator or a routed signal.
// - Master timebase is the reference offered to every subsystem.
// - 20 MHz timebase is the master timebase divided down.
// - 100 kHz timebase is the 20 MHz timebase divided by 200.
// - Each counter may pick the 20 MHz or 100 kHz timebase as source.
// - Reference selector takes bus, terminal, backplane and star lines.
// - A selected external reference feeds the loop making all timebases.
// - Loop enable may only change while no subsystem task is running.
// - A 10 MHz reference output is derived from the onboard oscillator.
// - 10 MHz reference may drive any bus, backplane or terminal line.
// - Counter k source, period source and A default to terminal 39-4k.
// - Counter k direction, two-edge start and B default to terminal 37-4k.
// - Counter k gate, two-edge stop and Z default to terminal 38-4k.
// - Counter k output drives terminal 36-4k by default.
// - Every default route may be replaced by configuration.
// - Each counter has eight selectable input ports fed by route muxes.
package tbg_pkg;
	localparam int NUM_CTR = 8;
	localparam int NUM_PORT = 8;
	localparam int NUM_SRC = 60;
	localparam int NUM_OUT = 56;
	localparam int SEL_W = 6;
	localparam int OSEL_W = 4;
	// Source indices: bus lines, terminals, backplane lines, then singles
	localparam int SRC_BUS = 0;
	localparam int SRC_TERM = 8;
	localparam int SRC_BPT = 48;
	localparam int SRC_CLK100 = 56;
	localparam int SRC_STAR = 57;
	localparam int SRC_DSTAR_A = 58;
	localparam int SRC_DSTAR_B = 59;
	localparam logic [SEL_W-1:0] SEL_TB20 = 6'h3C;
	localparam logic [SEL_W-1:0] SEL_TB100K = 6'h3D;
	localparam logic [SEL_W-1:0] SEL_MASTER = 6'h3E;
	localparam logic [SEL_W-1:0] SEL_NONE = 6'h3F;
	// Output route codes: 0 idle, 1..8 counter output, 9 10 MHz reference
	localparam logic [OSEL_W-1:0] OSEL_NONE = 4'h0;
	localparam logic [OSEL_W-1:0] OSEL_REF10 = 4'h9;
	// Counter input ports
	localparam int PORT_SRC = 0;
	localparam int PORT_GATE = 1;
	localparam int PORT_AUX = 2;
	localparam int PORT_ARM = 3;
	localparam int PORT_A = 4;
	localparam int PORT_B = 5;
	localparam int PORT_Z = 6;
	localparam int PORT_SCLK = 7;
	// Default terminal bases, stepping down by four per counter
	localparam int DEF_SRC_TERM = 39;
	localparam int DEF_DIR_TERM = 37;
	localparam int DEF_GATE_TERM = 38;
	localparam int DEF_OUT_TERM = 36;
	localparam int DEF_STEP = 4;
	// Register map
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h01;
	localparam logic [7:0] ADDR_IN_BASE = 8'h40;
	localparam logic [7:0] ADDR_OUT_BASE = 8'h80;
	localparam int CTRL_EN_BIT = 6;
	localparam int ST_PLL_BIT = 0;
	localparam int ST_REFUSED_BIT = 1;
	localparam int ST_BUSY_BIT = 2;
	localparam logic [SEL_W-1:0] CTRL_SEL_RST = 6'h00;
	// Timing: master 100 MHz, 20 MHz and 10 MHz derived by tick counts
	localparam int MASTER_MHZ = 100;
	localparam int TB20_MHZ = 20;
	localparam int REF10_MHZ = 10;
	localparam int DIV20 = MASTER_MHZ / TB20_MHZ;
	localparam int DIV100K = 200;
	localparam int REF10_HALF = MASTER_MHZ / REF10_MHZ / 2;
endpackage

// ### rtl/tbg_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module tbg_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1_q, s2_q, s3_q, dout_q, dout_d;

	// Second and third stage must agree; first stage feeds only the second
	always_comb begin
		for (int i = 0; i < W; i++) begin
			dout_d[i] = (s2_q[i] == s3_q[i]) ? s2_q[i] : dout_q[i];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			dout_q <= '0;
		end else if (ce) begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			dout_q <= dout_d;
		end
	end

	assign dout = dout_q;
endmodule

// ### rtl/tbg_core.sv
// Timebase generation, reference selection and counter signal routing
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module tbg_core
	import tbg_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic osc_tick,
	input wire logic pll_tick,
	input wire logic tasks_busy,
	input wire logic [7:0] trig_bus_i,
	input wire logic [39:0] term_i,
	input wire logic [7:0] bp_trig_i,
	input wire logic bp_clk100_i,
	input wire logic star_i,
	input wire logic dstar_a_i,
	input wire logic dstar_b_i,
	input wire logic [NUM_CTR-1:0] ctr_out,
	output logic [NUM_CTR*NUM_PORT-1:0] ctr_in,
	output logic pll_en,
	output logic pll_ref,
	output logic tb_master_tick,
	output logic tb20_tick,
	output logic tb100k_tick,
	output logic ref10_clk,
	output logic [NUM_OUT-1:0] pin_o,
	output logic [NUM_OUT-1:0] pin_oe_n
);
	logic [NUM_SRC-1:0] src_raw, src_s;
	logic [SEL_W-1:0] ref_sel_q, ref_sel_d;
	logic pll_en_q, pll_en_d, refused_q, refused_d;
	logic [SEL_W-1:0] in_sel_q [NUM_CTR*NUM_PORT];
	logic [SEL_W-1:0] in_sel_d [NUM_CTR*NUM_PORT];
	logic [OSEL_W-1:0] out_sel_q [NUM_OUT];
	logic [OSEL_W-1:0] out_sel_d [NUM_OUT];
	logic [7:0] rdata_q, rdata_d;
	logic [2:0] div20_q, div20_d;
	logic [7:0] div100k_q, div100k_d;
	logic [2:0] ref_cnt_q, ref_cnt_d;
	logic ref10_q, ref10_d;
	logic master_q, master_d, tb20_q, tb20_d, tb100k_q, tb100k_d;
	logic pll_ref_q, pll_ref_d;
	logic [NUM_CTR*NUM_PORT-1:0] ctr_in_q, ctr_in_d;
	logic [NUM_OUT-1:0] pin_q, pin_d, oe_n_q, oe_n_d;
	logic master_src, origin_chg;
	logic ctrl_wr, in_wr, out_wr;

	// Refused at elaboration: the selector codes and divider widths are fixed
	if (NUM_SRC > int'(SEL_TB20) || DIV20 < 2 || DIV100K > 256) begin : g_chk
		$error("tbg_core: constants exceed selector or divider width");
	end

	assign src_raw = {dstar_b_i, dstar_a_i, star_i, bp_clk100_i, bp_trig_i,
		term_i, trig_bus_i};

	tbg_sync #(.W(NUM_SRC)) u_sync (
		.clk(clk),
		.arst_n(arst_n),
		.ce(ce),
		.din(src_raw),
		.dout(src_s)
	);

	// Default route for counter k port p
	function automatic logic [SEL_W-1:0] def_in(input int idx);
		int k;
		int p;
		int t;
		k = idx / NUM_PORT;
		p = idx % NUM_PORT;
		case (p)
			PORT_SRC, PORT_A: t = DEF_SRC_TERM - DEF_STEP * k;
			PORT_AUX, PORT_B: t = DEF_DIR_TERM - DEF_STEP * k;
			PORT_GATE, PORT_Z: t = DEF_GATE_TERM - DEF_STEP * k;
			default: t = -1;
		endcase
		if (t < 0)
			return SEL_NONE;
		return SEL_W'(SRC_TERM + t);
	endfunction

	function automatic logic [OSEL_W-1:0] def_out(input int idx);
		int k;
		def_out = OSEL_NONE;
		for (k = 0; k < NUM_CTR; k++) begin
			if (idx == SRC_TERM + DEF_OUT_TERM - DEF_STEP * k)
				def_out = OSEL_W'(k + 1);
		end
	endfunction

	function automatic logic pick(input logic [SEL_W-1:0] sel,
		input logic [NUM_SRC-1:0] s, input logic t20, input logic t100k,
		input logic tm);
		if (sel < SEL_W'(NUM_SRC))
			return s[sel];
		case (sel)
			SEL_TB20: return t20;
			SEL_TB100K: return t100k;
			SEL_MASTER: return tm;
			default: return 1'b0;
		endcase
	endfunction

	assign ctrl_wr = ce && wr && addr == ADDR_CTRL;
	assign in_wr = ce && wr && addr[7:6] == ADDR_IN_BASE[7:6];
	assign out_wr = ce && wr && addr >= ADDR_OUT_BASE
		&& addr < ADDR_OUT_BASE + 8'(NUM_OUT);

	// Control: reference select and loop enable
	always_comb begin
		ref_sel_d = ref_sel_q;
		pll_en_d = pll_en_q;
		refused_d = refused_q;
		if (wr && addr == ADDR_STATUS && wdata[ST_REFUSED_BIT])
			refused_d = 1'b0;
		if (ctrl_wr) begin
			if (tasks_busy && (wdata[CTRL_EN_BIT] != pll_en_q
				|| (pll_en_q && wdata[SEL_W-1:0] != ref_sel_q))) begin
				refused_d = 1'b1;
			end else begin
				pll_en_d = wdata[CTRL_EN_BIT];
				ref_sel_d = wdata[SEL_W-1:0];
			end
		end
	end

	// Route tables; the reference may come from any of the 60 sources, not a timebase
	always_comb begin
		for (int i = 0; i < NUM_CTR * NUM_PORT; i++)
			in_sel_d[i] = in_sel_q[i];
		for (int i = 0; i < NUM_OUT; i++)
			out_sel_d[i] = out_sel_q[i];
		if (in_wr)
			in_sel_d[addr[5:0]] = wdata[SEL_W-1:0];
		if (out_wr)
			out_sel_d[6'(addr - ADDR_OUT_BASE)] = wdata[OSEL_W-1:0];
	end

	always_comb begin
		rdata_d = 8'h00;
		if (rd) begin
			if (addr == ADDR_CTRL)
				rdata_d = {1'b0, pll_en_q, ref_sel_q};
			else if (addr == ADDR_STATUS)
				rdata_d = {5'h00, tasks_busy, refused_q, pll_en_q};
			else if (addr[7:6] == ADDR_IN_BASE[7:6])
				rdata_d = {2'b00, in_sel_q[addr[5:0]]};
			else if (addr >= ADDR_OUT_BASE
				&& addr < ADDR_OUT_BASE + 8'(NUM_OUT))
				rdata_d = {4'h0, out_sel_q[6'(addr - ADDR_OUT_BASE)]};
		end
	end

	// Timebases: origin mux then two dividers
	assign master_src = pll_en_q ? pll_tick : osc_tick;
	assign origin_chg = pll_en_d != pll_en_q;

	always_comb begin
		div20_d = div20_q;
		div100k_d = div100k_q;
		tb20_d = 1'b0;
		tb100k_d = 1'b0;
		master_d = master_src;
		if (origin_chg) begin
			div20_d = '0;
			div100k_d = '0;
			master_d = 1'b0;
		end else if (master_src) begin
			if (div20_q == 3'(DIV20 - 1)) begin
				div20_d = '0;
				tb20_d = 1'b1;
				if (div100k_q == 8'(DIV100K - 1)) begin
					div100k_d = '0;
					tb100k_d = 1'b1;
				end else begin
					div100k_d = div100k_q + 8'h01;
				end
			end else begin
				div20_d = div20_q + 3'h1;
			end
		end
	end

	// The 10 MHz reference always follows the oscillator, never the loop
	always_comb begin
		ref_cnt_d = ref_cnt_q;
		ref10_d = ref10_q;
		if (osc_tick) begin
			if (ref_cnt_q == 3'(REF10_HALF - 1)) begin
				ref_cnt_d = '0;
				ref10_d = ~ref10_q;
			end else begin
				ref_cnt_d = ref_cnt_q + 3'h1;
			end
		end
	end

	// Routed signals
	always_comb begin
		pll_ref_d = pll_en_q && pick(ref_sel_q, src_s, 1'b0, 1'b0, 1'b0);
		for (int i = 0; i < NUM_CTR * NUM_PORT; i++)
			ctr_in_d[i] = pick(in_sel_q[i], src_s, tb20_q, tb100k_q,
				master_q);
		for (int i = 0; i < NUM_OUT; i++) begin
			oe_n_d[i] = out_sel_q[i] == OSEL_NONE;
			if (out_sel_q[i] == OSEL_REF10)
				pin_d[i] = ref10_q;
			else if (out_sel_q[i] != OSEL_NONE && out_sel_q[i] <= 4'(NUM_CTR))
				pin_d[i] = ctr_out[3'(out_sel_q[i] - 4'h1)];
			else
				pin_d[i] = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ref_sel_q <= CTRL_SEL_RST;
			pll_en_q <= 1'b0;
			refused_q <= 1'b0;
			for (int i = 0; i < NUM_CTR * NUM_PORT; i++)
				in_sel_q[i] <= def_in(i);
			for (int i = 0; i < NUM_OUT; i++)
				out_sel_q[i] <= def_out(i);
			rdata_q <= 8'h00;
			div20_q <= '0;
			div100k_q <= '0;
			ref_cnt_q <= '0;
			ref10_q <= 1'b0;
			master_q <= 1'b0;
			tb20_q <= 1'b0;
			tb100k_q <= 1'b0;
			pll_ref_q <= 1'b0;
			ctr_in_q <= '0;
			pin_q <= '0;
			oe_n_q <= '1;
		end else if (ce) begin
			ref_sel_q <= ref_sel_d;
			pll_en_q <= pll_en_d;
			refused_q <= refused_d;
			in_sel_q <= in_sel_d;
			out_sel_q <= out_sel_d;
			rdata_q <= rdata_d;
			div20_q <= div20_d;
			div100k_q <= div100k_d;
			ref_cnt_q <= ref_cnt_d;
			ref10_q <= ref10_d;
			master_q <= master_d;
			tb20_q <= tb20_d;
			tb100k_q <= tb100k_d;
			pll_ref_q <= pll_ref_d;
			ctr_in_q <= ctr_in_d;
			pin_q <= pin_d;
			oe_n_q <= oe_n_d;
		end
	end

	assign rdata = rdata_q;
	assign pll_en = pll_en_q;
	assign pll_ref = pll_ref_q;
	assign tb_master_tick = master_q;
	assign tb20_tick = tb20_q;
	assign tb100k_tick = tb100k_q;
	assign ref10_clk = ref10_q;
	assign ctr_in = ctr_in_q;
	assign pin_o = pin_q;
	assign pin_oe_n = oe_n_q;

	// Helper: count 20 MHz ticks since the last 100 kHz tick or origin change
	logic [7:0] a_tb20_cnt;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			a_tb20_cnt <= 8'h00;
		else if (ce && (tb100k_q || origin_chg))
			a_tb20_cnt <= 8'h00;
		else if (ce && tb20_q)
			a_tb20_cnt <= a_tb20_cnt + 8'h01;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	property p_loop_busy;
		ce && tasks_busy |=> $stable(pll_en_q);
	endproperty
	a_loop_busy: assert property (p_loop_busy)
		else $error("loop enable changed while busy");

	property p_refuse_flag;
		ctrl_wr && tasks_busy && wdata[CTRL_EN_BIT] != pll_en_q |=> refused_q;
	endproperty
	a_refuse_flag: assert property (p_refuse_flag)
		else $error("refused write not flagged");

	property p_origin;
		ce && !origin_chg && osc_tick && !pll_tick |=> master_q == !pll_en_q;
	endproperty
	a_origin: assert property (p_origin)
		else $error("master tick from wrong origin");

	property p_div20;
		ce && $past(ce) && tb20_q |-> $past(div20_q) == 3'(DIV20 - 1);
	endproperty
	a_div20: assert property (p_div20)
		else $error("20 MHz tick at wrong count");

	property p_div100k;
		ce && tb100k_q && !$past(origin_chg) |-> a_tb20_cnt == 8'(DIV100K - 1);
	endproperty
	a_div100k: assert property (p_div100k)
		else $error("100 kHz tick not after 200 ticks of 20 MHz");

	property p_restart;
		ce && origin_chg |=> div20_q == '0 && div100k_q == '0 && !tb20_q;
	endproperty
	a_restart: assert property (p_restart)
		else $error("dividers not restarted on origin change");

	property p_ref10;
		ce && osc_tick && ref_cnt_q == 3'(REF10_HALF - 1)
		|=> ref10_q != $past(ref10_q);
	endproperty
	a_ref10: assert property (p_ref10)
		else $error("10 MHz reference did not toggle");

	property p_out_route;
		ce && out_sel_q[SRC_TERM + DEF_OUT_TERM] == 4'h1
		|=> !pin_oe_n[SRC_TERM + DEF_OUT_TERM]
		&& pin_o[SRC_TERM + DEF_OUT_TERM] == $past(ctr_out[0]);
	endproperty
	a_out_route: assert property (p_out_route)
		else $error("counter zero output not on its terminal");

	property p_in_route;
		ce && in_sel_q[PORT_SRC] == SEL_W'(SRC_TERM + DEF_SRC_TERM)
		|=> ctr_in_q[PORT_SRC] == $past(src_s[SRC_TERM + DEF_SRC_TERM]);
	endproperty
	a_in_route: assert property (p_in_route)
		else $error("counter zero source not routed");

	property p_pll_ref;
		ce && !pll_en_q |=> !pll_ref_q;
	endproperty
	a_pll_ref: assert property (p_pll_ref)
		else $error("reference driven with loop off");
endmodule

// ### verification/tbg_far_model.sv
// Behavioural clock and backplane sources facing the block
`timescale 1ns/1ps
module tbg_far_model (
	input wire logic clk,
	input wire logic arst_n,
	output logic osc_tick,
	output logic pll_tick,
	output logic bp_clk100_i,
	output logic star_i,
	output logic dstar_a_i,
	output logic dstar_b_i
);
	int n_q;
	int n_d;
	always_comb begin
		n_d = (n_q + 1) % 60;
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			n_q <= 0;
		end else begin
			n_q <= n_d;
		end
	end
	// Slowed to the bench clock so the pin filter passes every level
	always_comb begin
		osc_tick = n_q[0];
		pll_tick = (n_q % 3) == 0;
		bp_clk100_i = n_q[1];
		star_i = (n_q % 20) < 2;
		dstar_a_i = (n_q % 20) < 10;
		dstar_b_i = (n_q % 10) < 5;
	end
endmodule

// ### verification/timebase_gen_and_counter_routing_tb.sv
// Self-checking bench for the timebase and routing block
`timescale 1ns/1ps
module timebase_gen_and_counter_routing_tb;
	import tbg_pkg::*;
	logic clk = 1'h0;
	logic arst_n = 1'h0;
	logic ce = 1'h1;
	logic wr = 1'h0;
	logic rd = 1'h0;
	logic tasks_busy = 1'h0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] trig_bus_i = 8'h00;
	logic [7:0] bp_trig_i = 8'h00;
	logic [7:0] ctr_out = 8'h00;
	logic [39:0] term_i = 40'h0;
	logic [7:0] rdata;
	logic osc_tick, pll_tick, bp_clk100_i, star_i, dstar_a_i, dstar_b_i;
	logic [63:0] ctr_in;
	logic pll_en, pll_ref, tbm, tb20, tb100k, ref10;
	logic [55:0] pin_o, pin_oe_n;
	logic [39:0] pat [2] = '{40'hC639AC639A, 40'h39C6539C65};
	logic [7:0] src_tab [11] = '{8'h05, 8'h06, 8'h08, 8'h32, 8'h38,
		8'h39, 8'h3A, 8'h3B, 8'h3C, 8'h3E, 8'h3F};
	int exp_tab [11] = '{100, 0, 100, 100, 50, 10, 50, 50, 10, 50, 0};
	int errors = 0;
	int checked = 0;

	tbg_far_model far (.clk(clk), .arst_n(arst_n), .osc_tick(osc_tick),
		.pll_tick(pll_tick), .bp_clk100_i(bp_clk100_i), .star_i(star_i),
		.dstar_a_i(dstar_a_i), .dstar_b_i(dstar_b_i));
	tbg_core dut (.clk(clk), .arst_n(arst_n), .ce(ce), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.osc_tick(osc_tick), .pll_tick(pll_tick), .tasks_busy(tasks_busy),
		.trig_bus_i(trig_bus_i), .term_i(term_i), .bp_trig_i(bp_trig_i),
		.bp_clk100_i(bp_clk100_i), .star_i(star_i), .dstar_a_i(dstar_a_i),
		.dstar_b_i(dstar_b_i), .ctr_out(ctr_out), .ctr_in(ctr_in),
		.pll_en(pll_en), .pll_ref(pll_ref), .tb_master_tick(tbm),
		.tb20_tick(tb20), .tb100k_tick(tb100k), .ref10_clk(ref10),
		.pin_o(pin_o), .pin_oe_n(pin_oe_n));

	initial begin
		forever #50 clk = ~clk;
	end

	task automatic check(input string what, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, d);
		@(posedge clk);
		wr <= 1'h1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'h0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		rd <= 1'h1;
		addr <= a;
		@(posedge clk);
		rd <= 1'h0;
		#1 d = rdata;
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	function automatic logic pick(input int i);
		case (i)
			64: return tbm;
			65: return tb20;
			66: return tb100k;
			67: return ref10;
			default: return (i >= 100) ? pin_o[i-100] : ctr_in[i];
		endcase
	endfunction

	// Whole periods are counted so the result does not depend on phase
	task automatic ones(input int i, n, output int c);
		c = 0;
		repeat (n) begin
			@(posedge clk);
			#1;
			if (pick(i) === 1'h1) c++;
		end
	endtask

	task automatic stop_test;
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge clk);
		errors++;
		stop_test;
	end

	initial begin
		logic [7:0] d;
		logic h;
		int c;
		int k;
		repeat (16) @(posedge clk);
		#1;
		check("oe_rst", {pll_en, &pin_oe_n}, 2'h1);
		arst_n <= 1'h1;
		rd_reg(ADDR_CTRL, d);
		check("ctrl_rst", d, 8'h00);
		rd_reg(ADDR_STATUS, d);
		check("stat_rst", d, 8'h00);
		rd_reg(8'h02, d);
		check("unmapped", d, 8'h00);
		foreach (pat[j]) begin
			term_i <= pat[j];
			wait_cyc(8);
			for (k = 0; k < 8; k++) begin
				check("src", ctr_in[k*8+PORT_SRC], pat[j][39-4*k]);
				check("enc_a", ctr_in[k*8+PORT_A], pat[j][39-4*k]);
				check("gate", ctr_in[k*8+PORT_GATE], pat[j][38-4*k]);
				check("enc_z", ctr_in[k*8+PORT_Z], pat[j][38-4*k]);
				check("enc_b", ctr_in[k*8+PORT_B], pat[j][37-4*k]);
				check("aux", ctr_in[k*8+PORT_AUX], pat[j][37-4*k]);
				check("arm", ctr_in[k*8+PORT_ARM], 1'h0);
				check("sclk", ctr_in[k*8+PORT_SCLK], 1'h0);
			end
		end
		for (int r = 0; r < 2; r++) begin
			ctr_out <= (r == 0) ? 8'h5A : 8'hA5;
			wait_cyc(3);
			for (k = 0; k < 8; k++) begin
				check("cout", {pin_oe_n[44-4*k], pin_o[44-4*k]}, ctr_out[k]);
			end
		end
		ones(64, 100, c);
		check("master", c, 50);
		ones(65, 100, c);
		check("tb20", c, 10);
		ones(66, 4000, c);
		check("tb100k", c, 2);
		ones(67, 200, c);
		check("ref10", c, 100);
		// With the enable low the 10 MHz reference register must hold its value
		h = ref10;
		ce <= 1'h0;
		ones(67, 20, c);
		check("ce_hold", c, h ? 20 : 0);
		ce <= 1'h1;
		wr_reg(ADDR_OUT_BASE, 8'h03);
		wait_cyc(3);
		check("out_rt", {pin_oe_n[0], pin_o[0]}, ctr_out[2]);
		wr_reg(ADDR_OUT_BASE + 8'h37, OSEL_REF10);
		wait_cyc(3);
		ones(155, 200, c);
		check("ref_pin", c, 100);
		wr_reg(ADDR_OUT_BASE + 8'h37, OSEL_NONE);
		wait_cyc(3);
		check("out_off", pin_oe_n[55], 1'h1);
		term_i <= 40'h01;
		trig_bus_i <= 8'h20;
		bp_trig_i <= 8'h04;
		foreach (src_tab[j]) begin
			wr_reg(ADDR_IN_BASE + 8'h19, src_tab[j]);
			wait_cyc(10);
			ones(25, 100, c);
			check("route", c, exp_tab[j]);
		end
		wr_reg(ADDR_IN_BASE + 8'h19, 8'h3D);
		wait_cyc(10);
		ones(25, 4000, c);
		check("route_100k", c, 2);
		term_i <= 40'h20;
		tasks_busy <= 1'h1;
		wr_reg(ADDR_CTRL, 8'h4D);
		wait_cyc(2);
		rd_reg(ADDR_STATUS, d);
		check("refused", {pll_en, d}, 9'h006);
		wr_reg(ADDR_STATUS, 8'h02);
		tasks_busy <= 1'h0;
		wr_reg(ADDR_CTRL, 8'h4D);
		wait_cyc(8);
		rd_reg(ADDR_STATUS, d);
		check("loop_on", {pll_en, pll_ref, d}, 10'h301);
		term_i <= 40'h00;
		wait_cyc(8);
		check("loop_ref", pll_ref, 1'h0);
		ones(64, 99, c);
		check("loop_m", c, 33);
		ones(65, 150, c);
		check("loop_20", c, 10);
		ones(67, 200, c);
		check("ref10_osc", c, 100);
		tasks_busy <= 1'h1;
		wr_reg(ADDR_CTRL, 8'h40);
		wr_reg(ADDR_CTRL, 8'h0D);
		wait_cyc(2);
		rd_reg(ADDR_STATUS, d);
		check("refused2", {pll_en, d}, 9'h107);
		tasks_busy <= 1'h0;
		wr_reg(ADDR_CTRL, 8'h0D);
		wait_cyc(3);
		check("loop_off", {pll_en, pll_ref}, 2'h0);
		ones(64, 100, c);
		check("osc_back", c, 50);
		// Mid-run reset must bring back the default routes
		term_i <= 40'h0004000000;
		arst_n <= 1'h0;
		wait_cyc(2);
		check("oe_rst2", pin_oe_n[0], 1'h1);
		arst_n <= 1'h1;
		wait_cyc(8);
		check("rt_rst", {pin_oe_n[0], ctr_in[25]}, 2'h3);
		rd_reg(ADDR_CTRL, d);
		check("ctrl_rst2", d, 8'h00);
		stop_test;
	end
endmodule
